// [src/prm_readout.v]
`timescale 1ns/1ns
`include "prm_consts.vh"

// Overview of operation
// - Calibration memory answers reads only at 0xA1.
// - Converter answers at 0xEE write, 0xEF read.
// - Calibration reads act like serial EEPROM reads.
// - Result returned high byte, then low byte.
module prm_readout
#(
  parameter CONV_TICKS = `PRM_CONV_TICKS
)
(
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe_n,
  input  wire        converter_reset_n,
  input  wire        conv_clk,
  input  wire [15:0] raw_pressure,
  input  wire [15:0] raw_temperature,
  output reg         conv_busy
);

  localparam integer TICK_LAST = CONV_TICKS - 1;

  reg                  scl_m;
  reg                  scl_q;
  reg                  scl_p;
  reg                  sda_m;
  reg                  sda_q;
  reg                  sda_p;
  reg                  cclk_m;
  reg                  cclk_q;
  reg                  cclk_p;
  reg                  crst_m;
  reg                  crst_q;
  reg  [4:0]           state;
  reg  [3:0]           bcnt;
  reg  [7:0]           shreg;
  reg                  first_byte;
  reg                  tgt_adc;
  reg                  is_read;
  reg  [1:0]           wr_idx;
  reg                  rd_idx;
  reg  [7:0]           cal_ptr;
  reg  [7:0]           adc_reg;
  reg                  pend_press;
  reg                  pend_temp;
  reg                  kind_press;
  reg  [`PRM_TICK_W-1:0] tick_cnt;
  reg  [15:0]          result;
  reg  [7:0]           tx_byte;
  wire [7:0]           cal_data;
  wire                 scl_rise;
  wire                 scl_fall;
  wire                 bus_start;
  wire                 bus_stop;
  wire                 cclk_rise;
  wire                 addr_hit;

  // Bus pins and conversion clock pass three flops, converter reset two; edge logic only looks at the later two.
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      scl_m  <= 1'b1;
      scl_q  <= 1'b1;
      scl_p  <= 1'b1;
      sda_m  <= 1'b1;
      sda_q  <= 1'b1;
      sda_p  <= 1'b1;
      cclk_m <= 1'b0;
      cclk_q <= 1'b0;
      cclk_p <= 1'b0;
      crst_m <= 1'b0;
      crst_q <= 1'b0;
    end
    else
    begin
      scl_m  <= scl_in;
      scl_q  <= scl_m;
      scl_p  <= scl_q;
      sda_m  <= sda_in;
      sda_q  <= sda_m;
      sda_p  <= sda_q;
      cclk_m <= conv_clk;
      cclk_q <= cclk_m;
      cclk_p <= cclk_q;
      crst_m <= converter_reset_n;
      crst_q <= crst_m;
    end
  end

  assign scl_rise  = scl_q & ~scl_p;
  assign scl_fall  = ~scl_q & scl_p;
  assign bus_start = scl_q & scl_p & sda_p & ~sda_q;
  assign bus_stop  = scl_q & scl_p & ~sda_p & sda_q;
  assign cclk_rise = cclk_q & ~cclk_p;

  // Address decode
  // The calibration write address is taken only to load the pointer.
  assign addr_hit = (shreg == `PRM_CAL_RD_ADDR) ||
                    (shreg == `PRM_CAL_WR_ADDR) ||
                    (shreg == `PRM_ADC_WR_ADDR) ||
                    (shreg == `PRM_ADC_RD_ADDR);

  prm_cal_rom u_cal_rom
  (
    .addr (cal_ptr),
    .data (cal_data)
  );

  always @*
  begin
    tx_byte = cal_data;
    if (tgt_adc)
    begin
      if (adc_reg != `PRM_REG_RESULT)
        tx_byte = `PRM_BYTE_ZERO;
      else if (rd_idx)
        tx_byte = result[7:0];
      else
        tx_byte = result[15:8];
    end
  end

  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state      <= `PRM_ST_IDLE;
      bcnt       <= `PRM_CNT_ZERO;
      shreg      <= `PRM_BYTE_ZERO;
      first_byte <= 1'b0;
      tgt_adc    <= 1'b0;
      is_read    <= 1'b0;
      wr_idx     <= 2'b00;
      rd_idx     <= 1'b0;
      cal_ptr    <= `PRM_BYTE_ZERO;
      adc_reg    <= `PRM_BYTE_ZERO;
      pend_press <= 1'b0;
      pend_temp  <= 1'b0;
      sda_out    <= 1'b0;
      sda_oe_n   <= 1'b1;
    end
    else if (bus_start || bus_stop)
    begin
      state      <= bus_start ? `PRM_ST_RX : `PRM_ST_IDLE;
      bcnt       <= `PRM_CNT_ZERO;
      first_byte <= 1'b1;
      pend_press <= 1'b0;
      pend_temp  <= 1'b0;
      sda_oe_n   <= 1'b1;
    end
    else
    begin
      case (state)
        `PRM_ST_RX:
        begin
          if (scl_rise && bcnt != `PRM_BIT_LAST)
          begin
            shreg <= {shreg[6:0], sda_q};
            bcnt  <= bcnt + `PRM_CNT_ONE;
          end
          else if (scl_fall && bcnt == `PRM_BIT_LAST)
          begin
            state    <= `PRM_ST_ACK;
            sda_oe_n <= 1'b0;
            if (first_byte)
            begin
              first_byte <= 1'b0;
              tgt_adc    <= {shreg[7:1], 1'b1} == `PRM_ADC_RD_ADDR;
              is_read    <= shreg[0];
              wr_idx     <= 2'b00;
              rd_idx     <= 1'b0;
              if (!addr_hit)
              begin
                state    <= `PRM_ST_IDLE;
                sda_oe_n <= 1'b1;
              end
            end
            else
            begin
              if (wr_idx != 2'b11)
                wr_idx <= wr_idx + 2'b01;
              if (!tgt_adc && wr_idx == 2'b00)
                cal_ptr <= shreg;
              else if (tgt_adc && wr_idx == 2'b00)
                adc_reg <= shreg;
              else if (tgt_adc && wr_idx == 2'b01 &&
                       adc_reg == `PRM_REG_CMD &&
                       (shreg == `PRM_CMD_PRESS ||
                        shreg == `PRM_CMD_TEMP))
              begin
                pend_press <= shreg == `PRM_CMD_PRESS;
                pend_temp  <= shreg == `PRM_CMD_TEMP;
              end
              else
              begin
                state    <= `PRM_ST_IDLE;
                sda_oe_n <= 1'b1;
              end
            end
          end
        end
        `PRM_ST_ACK:
        begin
          if (scl_fall)
          begin
            bcnt <= `PRM_CNT_ZERO;
            if (is_read)
            begin
              state    <= `PRM_ST_TX;
              shreg    <= tx_byte;
              sda_oe_n <= tx_byte[7];
              rd_idx   <= ~rd_idx;
              if (!tgt_adc)
                cal_ptr <= cal_ptr + 8'h01;
            end
            else
            begin
              state    <= `PRM_ST_RX;
              sda_oe_n <= 1'b1;
            end
          end
        end
        `PRM_ST_TX:
        begin
          if (scl_rise)
            bcnt <= bcnt + `PRM_CNT_ONE;
          else if (scl_fall && bcnt == `PRM_BIT_LAST)
          begin
            state    <= `PRM_ST_MACK;
            sda_oe_n <= 1'b1;
          end
          else if (scl_fall)
          begin
            shreg    <= {shreg[6:0], 1'b1};
            sda_oe_n <= shreg[6];
          end
        end
        `PRM_ST_MACK:
        begin
          if (scl_rise && sda_q)
            state <= `PRM_ST_IDLE;
          else if (scl_fall)
          begin
            state    <= `PRM_ST_TX;
            bcnt     <= `PRM_CNT_ZERO;
            shreg    <= tx_byte;
            sda_oe_n <= tx_byte[7];
            rd_idx   <= ~rd_idx;
            if (!tgt_adc)
              cal_ptr <= cal_ptr + 8'h01;
          end
        end
        `PRM_ST_IDLE:
          sda_oe_n <= 1'b1;
        default:
        begin
          state    <= `PRM_ST_IDLE;
          sda_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // The result register holds its value through later reads, so a host
  // that reads early simply sees the previous conversion.
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      conv_busy  <= 1'b0;
      kind_press <= 1'b0;
      tick_cnt   <= {`PRM_TICK_W{1'b0}};
      result     <= {`PRM_BYTE_ZERO, `PRM_BYTE_ZERO};
    end
    else if (!crst_q)
    begin
      conv_busy <= 1'b0;
      tick_cnt  <= {`PRM_TICK_W{1'b0}};
    end
    else if (bus_stop && (pend_press || pend_temp))
    begin
      conv_busy  <= 1'b1;
      kind_press <= pend_press;
      tick_cnt   <= {`PRM_TICK_W{1'b0}};
    end
    else if (conv_busy && cclk_rise)
    begin
      tick_cnt <= tick_cnt + {{(`PRM_TICK_W-1){1'b0}}, 1'b1};
      if (tick_cnt == TICK_LAST[`PRM_TICK_W-1:0])
      begin
        conv_busy <= 1'b0;
        result    <= kind_press ? raw_pressure : raw_temperature;
      end
    end
  end

endmodule // prm_readout

// [src/prm_consts.vh]
`ifndef PRM_CONSTS_VH
`define PRM_CONSTS_VH

// Bus address bytes, read/write bit included.
`define PRM_CAL_RD_ADDR  8'ha1
`define PRM_CAL_WR_ADDR  8'ha0
`define PRM_ADC_WR_ADDR  8'hee
`define PRM_ADC_RD_ADDR  8'hef

// Converter register bytes and command bytes.
`define PRM_REG_CMD      8'hff
`define PRM_REG_RESULT   8'hfd
`define PRM_CMD_PRESS    8'hf0
`define PRM_CMD_TEMP     8'he8

// Calibration memory byte offsets; each word is high byte first.
`define PRM_OFS_SENSITIVITY_TERM     8'h10
`define PRM_OFS_OFFSET   8'h12
`define PRM_OFS_SENSITIVITY_TERM_TC  8'h14
`define PRM_OFS_OFF_TC   8'h16
`define PRM_OFS_REF_TEMP 8'h18
`define PRM_OFS_TSLOPE   8'h1a
`define PRM_OFS_FINE     8'h1c
`define PRM_OFS_UPPER    8'h1e
`define PRM_OFS_LOWER    8'h1f
`define PRM_OFS_CSHIFT   8'h20
`define PRM_OFS_TSHIFT   8'h21

// Byte engine figures.
`define PRM_BIT_LAST     4'h8
`define PRM_BYTE_ZERO    8'h00
`define PRM_CNT_ZERO     4'h0
`define PRM_CNT_ONE      4'h1

// Conversion length in conversion clock edges (31.25 ms at 32768 Hz).
`define PRM_CONV_TICKS   1024
`define PRM_TICK_W       11

// One-hot states of the serial engine.
`define PRM_ST_IDLE      5'h01
`define PRM_ST_RX        5'h02
`define PRM_ST_ACK       5'h04
`define PRM_ST_TX        5'h08
`define PRM_ST_MACK      5'h10

`endif

// [src/prm_cal_rom.v]
`timescale 1ns/1ns
`include "prm_consts.vh"

module prm_cal_rom
#(
  parameter [15:0] SENSITIVITY_COEFF = 16'h74d4,
  parameter [15:0] OFFSET_COEFF      = 16'h0e8c,
  parameter [15:0] SENSITIVITY_TERM_TEMP_COEFF   = 16'h0138,
  parameter [15:0] OFFSET_TEMP_COEFF = 16'h01b9,
  parameter [15:0] REFERENCE_TEMP    = 16'h23e7,
  parameter [15:0] TEMP_SLOPE_COEFF  = 16'h0f96,
  parameter [15:0] OFFSET_FINE_TUNE  = 16'h09c4,
  parameter [7:0]  UPPER_CURVE_GAIN  = 8'h01,
  parameter [7:0]  LOWER_CURVE_GAIN  = 8'h04,
  parameter [7:0]  CURVE_SHIFT       = 8'h04,
  parameter [7:0]  TEMP_TRIM_SHIFT   = 8'h09
)
(
  input  wire [7:0] addr,
  output reg  [7:0] data
);

  reg [15:0] word;

  always @*
  begin
    case ({addr[7:1], 1'b0})
      `PRM_OFS_SENSITIVITY_TERM:     word = SENSITIVITY_COEFF;
      `PRM_OFS_OFFSET:   word = OFFSET_COEFF;
      `PRM_OFS_SENSITIVITY_TERM_TC:  word = SENSITIVITY_TERM_TEMP_COEFF;
      `PRM_OFS_OFF_TC:   word = OFFSET_TEMP_COEFF;
      `PRM_OFS_REF_TEMP: word = REFERENCE_TEMP;
      `PRM_OFS_TSLOPE:   word = TEMP_SLOPE_COEFF;
      `PRM_OFS_FINE:     word = OFFSET_FINE_TUNE;
      default:           word = {`PRM_BYTE_ZERO, `PRM_BYTE_ZERO};
    endcase
    case (addr)
      `PRM_OFS_UPPER:  data = UPPER_CURVE_GAIN;
      `PRM_OFS_LOWER:  data = LOWER_CURVE_GAIN;
      `PRM_OFS_CSHIFT: data = CURVE_SHIFT;
      `PRM_OFS_TSHIFT: data = TEMP_TRIM_SHIFT;
      default:         data = addr[0] ? word[7:0] : word[15:8];
    endcase
  end

endmodule // prm_cal_rom

// [sim/prm_readout_checker.sv]
`timescale 1ns/1ns
module prm_readout_checker
#(
  parameter CONV_TICKS = 4
)
(
  input wire mclk,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  input wire sda_oe_n,
  input wire converter_reset_n,
  input wire conv_busy
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // The device may only start pulling the data line while the clock is low.
  oe_fall_a: assert property ($fell(sda_oe_n) |-> !scl_in)
    else $error("data line pulled while bus clock high");
  sda_stable_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
    else $error("device drive changed while bus clock high");
  busy_start_a: assert property ($rose(conv_busy) |-> scl_in && sda_in && converter_reset_n)
    else $error("conversion began outside a stop or under reset");
  // A conversion stays busy for at least eight system clocks after it starts.
  busy_hold_a: assert property (@(posedge mclk)
    disable iff (sys_rst || !converter_reset_n)
    $rose(conv_busy) |=> conv_busy [*8])
    else $error("conversion ended too early");
endmodule // prm_readout_checker

// [sim/prm_host.sv]
`timescale 1ns/1ns
module prm_host
(
  input  wire mclk,
  input  wire sda_wire,
  output reg  scl,
  output reg  sda_drv,
  output reg  converter_reset_n,
  output reg  conv_clk
);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
    converter_reset_n = 1'b0;
    conv_clk = 1'b0;
  end

  always #160 conv_clk = ~conv_clk;

  // The bus clock period is eight system clocks, four high and four low.
  // That is the least the device's three sampling stages can follow, so
  // data changes a quarter period after each falling edge.
  task hp;
    repeat (4) @(negedge mclk);
  endtask

  task qp;
    repeat (2) @(negedge mclk);
  endtask

  task start_c;
  begin
    sda_drv = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    sda_drv = 1'b0;
    hp;
    scl = 1'b0;
    hp;
  end
  endtask

  task stop_c;
  begin
    sda_drv = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    sda_drv = 1'b1;
    hp;
  end
  endtask

  task xfer(input [8:0] tx, output [8:0] rx);
    integer i;
  begin
    for (i = 8; i >= 0; i = i - 1)
    begin
      sda_drv = tx[i];
      qp;
      scl = 1'b1;
      hp;
      rx[i] = sda_wire;
      scl = 1'b0;
      qp;
    end
  end
  endtask

  task set_conv_rst(input v);
    converter_reset_n = v;
  endtask
endmodule // prm_host

// [sim/tb_prm_readout.sv]
`timescale 1ns/1ns
`include "prm_consts.vh"
module tb_prm_readout;
  localparam TICKS = 4;
  localparam [143:0] CAL = 144'h74d40e8c013801b923e70f9609c401040409;
  reg         mclk;
  reg         sys_rst;
  reg  [15:0] raw_pressure;
  reg  [15:0] raw_temperature;
  wire        scl;
  wire        sda_drv;
  wire        sda_out;
  wire        sda_oe_n;
  wire        converter_reset_n;
  wire        conv_clk;
  wire        conv_busy;
  wire        sda_wire = sda_drv & (sda_oe_n | sda_out);
  integer     num_errors;
  integer     cmp_count;
  integer     i;
  reg  [8:0]  rx;
  reg  [15:0] word;
  reg  [15:0] raw_p_seen;
  reg  [15:0] raw_t_seen;
  reg  [7:0]  cal [0:17];

  prm_readout #(.CONV_TICKS(TICKS)) u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .converter_reset_n(converter_reset_n), .conv_clk(conv_clk),
    .raw_pressure(raw_pressure), .raw_temperature(raw_temperature),
    .conv_busy(conv_busy));

  prm_host u_host (.mclk(mclk), .sda_wire(sda_wire), .scl(scl),
    .sda_drv(sda_drv), .converter_reset_n(converter_reset_n),
    .conv_clk(conv_clk));

  task check(input [15:0] seen, input [15:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  end
  endtask

  task test_done;
  begin
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask

  task wr(input [7:0] b, input ack);
  begin
    u_host.xfer({b, 1'b1}, rx);
    check({15'h0000, rx[0]}, {15'h0000, !ack});
  end
  endtask

  task rd(input last, output [7:0] b);
  begin
    u_host.xfer({8'hff, last}, rx);
    b = rx[8:1];
  end
  endtask

  // A refused command leaves the previous result in place.
  task convert(input [7:0] cmd, input ok, input [15:0] exp);
    integer k;
  begin
    u_host.set_conv_rst(1'b1);
    u_host.start_c;
    wr(`PRM_ADC_WR_ADDR, 1'b1);
    wr(`PRM_REG_CMD, 1'b1);
    wr(cmd, ok);
    u_host.stop_c;
    check({15'h0000, conv_busy}, {15'h0000, ok});
    k = 0;
    while (conv_busy === 1'b1 && k < 500)
    begin
      @(negedge mclk);
      k = k + 1;
    end
    check({15'h0000, conv_busy}, 16'h0000);
    u_host.start_c;
    wr(`PRM_ADC_WR_ADDR, 1'b1);
    wr(`PRM_REG_RESULT, 1'b1);
    u_host.start_c;
    wr(`PRM_ADC_RD_ADDR, 1'b1);
    rd(1'b0, word[15:8]);
    rd(1'b1, word[7:0]);
    u_host.stop_c;
    u_host.set_conv_rst(1'b0);
    check(word, exp);
  end
  endtask

  // Host compensation on what was read back. Integer division truncates,
  // so one count of slack is allowed for pressure, altitude and temperature; dut must match exactly.
  task compensate(input [15:0] d1, input [15:0] d2);
    integer c1, c2, c3, c4, c5, c6, c7, ga, gb, gc, gd;
    integer dt, sq, dut, off, sensitivity_term, x, pr, alt, t;
  begin
    c1 = {cal[0], cal[1]};
    c2 = {cal[2], cal[3]};
    c3 = {cal[4], cal[5]};
    c4 = {cal[6], cal[7]};
    c5 = {cal[8], cal[9]};
    c6 = {cal[10], cal[11]};
    c7 = {cal[12], cal[13]};
    ga = cal[14];
    gb = cal[15];
    gc = cal[16];
    gd = cal[17];
    dt = d2;
    dt = dt - c5;
    sq = dt * dt / 16384;
    dut = dt - sq * (dt >= 0 ? ga : gb) / (1 << gc);
    off = (c2 + (c4 - 1024) * dut / 16384) * 4;
    sensitivity_term = c1 + c3 * dut / 1024;
    x = d1;
    x = sensitivity_term * (x - 7168) / 16384 - off;
    pr = x * 10 / 32 + c7;
    alt = x * 100 / 32 + c7 * 10;
    t = 250 + dut * c6 / 65536 - dut / (1 << gd);
    check({15'h0000, dut == -5478}, 16'h0001);
    check({15'h0000, pr >= 9917 && pr <= 9919}, 16'h0001);
    check({15'h0000, alt / 10 >= 9917 && alt / 10 <= 9919}, 16'h0001);
    check({15'h0000, t >= -73 && t <= -71}, 16'h0001);
  end
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors = num_errors + 1;
    test_done;
  end

  initial
  begin
    num_errors = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    raw_pressure = 16'h7554;
    raw_temperature = 16'h100b;
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    u_host.start_c;
    wr(8'hec, 1'b0);
    u_host.stop_c;
    u_host.set_conv_rst(1'b0);
    u_host.start_c;
    wr(`PRM_CAL_WR_ADDR, 1'b1);
    wr(`PRM_OFS_SENSITIVITY_TERM, 1'b1);
    wr(8'h55, 1'b0);
    u_host.stop_c;
    u_host.start_c;
    wr(`PRM_CAL_WR_ADDR, 1'b1);
    wr(`PRM_OFS_SENSITIVITY_TERM, 1'b1);
    u_host.start_c;
    wr(`PRM_CAL_RD_ADDR, 1'b1);
    for (i = 0; i < 18; i = i + 1)
    begin
      rd(i == 17, word[7:0]);
      cal[i] = word[7:0];
      check({8'h00, word[7:0]}, {8'h00, CAL[143 - 8 * i -: 8]});
    end
    u_host.stop_c;
    u_host.start_c;
    wr(`PRM_CAL_RD_ADDR, 1'b1);
    rd(1'b1, word[7:0]);
    u_host.stop_c;
    check({8'h00, word[7:0]}, 16'h0000);
    // A real host would throw this first result away; here it is checked.
    convert(`PRM_CMD_PRESS, 1'b1, 16'h7554);
    raw_p_seen = word;
    convert(`PRM_CMD_TEMP, 1'b1, 16'h100b);
    raw_t_seen = word;
    compensate(raw_p_seen, raw_t_seen);
    raw_pressure = 16'h8a3c;
    // A conversion cut by the converter reset must not load a result.
    u_host.set_conv_rst(1'b1);
    u_host.start_c;
    wr(`PRM_ADC_WR_ADDR, 1'b1);
    wr(`PRM_REG_CMD, 1'b1);
    wr(`PRM_CMD_PRESS, 1'b1);
    u_host.stop_c;
    check({15'h0000, conv_busy}, 16'h0001);
    u_host.set_conv_rst(1'b0);
    repeat (4) @(negedge mclk);
    check({15'h0000, conv_busy}, 16'h0000);
    convert(8'he0, 1'b0, 16'h100b);
    convert(`PRM_CMD_PRESS, 1'b1, 16'h8a3c);
    test_done;
  end
endmodule // tb_prm_readout

bind prm_readout prm_readout_checker #(.CONV_TICKS(CONV_TICKS)) u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_oe_n(sda_oe_n), .converter_reset_n(converter_reset_n),
  .conv_busy(conv_busy));
